// ==== core/irq_ctrl_pkg.sv ====
// Constants shared by the priority interrupt controller.
package irq_ctrl_pkg;

  // **************************************************************
  // Source table
  // **************************************************************
  localparam int NUM_SOURCES = 60;
  localparam int NUM_FIXED = 10;
  localparam int NUM_CHANNELS = 8;
  localparam int WATCHDOG_IDX = 9;
  localparam int RESERVED_IDX = 8;
  localparam int XFER_DONE_BASE = 52;
  localparam int ILLEGAL_TRAP_IDX = 2;

  // **************************************************************
  // Levels and status register layout
  // **************************************************************
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  localparam logic [2:0] LEVEL_MIN = 3'h1;
  localparam logic [2:0] LEVEL_XFER = 3'h6;
  localparam logic [2:0] LEVEL_TOP = 3'h7;
  localparam int SR_MASK_LO = 12;
  localparam int SR_MASK_HI = 14;
  localparam logic [15:0] SR_RESET = 16'h7000;

  // **************************************************************
  // Vector area
  // **************************************************************
  localparam logic [23:0] VECTOR_BASE = 24'hFFFF00;
  localparam int VECTOR_SHIFT = 2;

  // **************************************************************
  // Register offsets (byte addresses)
  // **************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PEND_LO = 8'h04;
  localparam logic [7:0] REG_PEND_HI = 8'h08;
  localparam logic [7:0] REG_LEVEL_BASE = 8'h10;
  localparam logic [7:0] REG_LEVEL_END = 8'h2C;
  localparam logic [7:0] REG_START_BASE = 8'h40;
  localparam logic [7:0] REG_START_END = 8'h5C;
  localparam int LEVELS_PER_WORD = 8;
  localparam int LEVEL_FIELD = 4;

  // **************************************************************
  // Instruction kinds and sequencer states
  // **************************************************************
  typedef enum logic [1:0] {
    OP_MASK_SET,
    OP_MASK_ALL,
    OP_RETURN,
    OP_NONE
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH,
    ST_FETCH,
    ST_JUMP,
    ST_HOLD
  } seq_state_t;

endpackage

// ==== core/priority_interrupt_controller.sv ====
// Prioritised interrupt controller with the CPU acceptance sequencer.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module priority_interrupt_controller
  import irq_ctrl_pkg::*;
#(
  parameter int NSRC = irq_ctrl_pkg::NUM_SOURCES,
  parameter int NCH = irq_ctrl_pkg::NUM_CHANNELS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM register slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Peripheral events, one-cycle pulses on this clock
  input wire logic [NSRC-1:0] irqEvent,
  // Instruction sequencer
  input wire logic instrBoundary,
  input wire logic instrDone,
  input wire logic opValid,
  input wire irq_ctrl_pkg::op_kind_t opKind,
  input wire logic [2:0] opArg,
  input wire logic [15:0] retSr,
  input wire logic trapReq,
  input wire logic [2:0] trapNum,
  input wire logic illegalReq,
  input wire logic [23:0] pcIn,
  input wire logic [31:0] stackPointer,
  // Handler fetch
  input wire logic fetchAck,
  input wire logic [23:0] fetchData,
  // Transfer engine
  input wire logic xferEnd,
  input wire logic [2:0] xferEndCh,
  // Context push, fetch and jump
  output logic pushValid,
  output logic [31:0] pushAddr,
  output logic [23:0] pushPc,
  output logic [15:0] pushSr,
  output logic fetchReq,
  output logic [23:0] fetchAddr,
  output logic jumpValid,
  output logic [23:0] jumpTarget,
  // Status towards the CPU core
  output logic [15:0] statusReg,
  output logic [7:0] nestDepth,
  output logic accepted,
  output logic [7:0] acceptedVector,
  // Transfer start towards the engine
  output logic xferGo,
  output logic [2:0] xferCh
);
  import irq_ctrl_pkg::*;

  initial begin
    if (NSRC <= XFER_DONE_BASE + NCH - 1 || NSRC > 64 || NCH != 8) begin
      $error("Unsupported source or channel count.");
    end
  end

  // **************************************************************
  // State
  // **************************************************************
  typedef struct packed {
    seq_state_t st;
    logic [15:0] sr;
    logic [7:0] nest;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0][2:0] level;
    logic [NCH-1:0][7:0] startCode;
    logic wait_;
    logic [31:0] rdata;
    logic pushValid;
    logic [31:0] pushAddr;
    logic [23:0] pushPc;
    logic [15:0] pushSr;
    logic fetchReq;
    logic [23:0] fetchAddr;
    logic jumpValid;
    logic [23:0] jumpTarget;
    logic accepted;
    logic [7:0] vector;
    logic xferGo;
    logic [2:0] xferCh;
  } state_t;

  state_t s_q;
  state_t s_d;

  // **************************************************************
  // Decoding helpers
  // **************************************************************
  // Lowest numbered channel wins when two carry the same start code.
  function automatic logic [3:0] route(
    input logic [NCH-1:0][7:0] codes, input int idx);
    logic [3:0] r;
    r = 4'h0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (codes[c] == 8'(idx) && codes[c] != 8'h00) begin
        r = {1'b1, 3'(c)};
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] effLevel(
    input logic pend, input logic [2:0] lvl, input logic routed,
    input int idx);
    logic [2:0] e;
    e = LEVEL_NONE;
    if (pend) begin
      if (idx == WATCHDOG_IDX) begin
        e = LEVEL_TOP;
      end else if (routed) begin
        e = LEVEL_XFER;
      end else if (lvl != LEVEL_TOP) begin
        e = lvl;
      end
    end
    return e;
  endfunction

  function automatic logic [7:0] vectorOf(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  // **************************************************************
  // Priority resolution
  // **************************************************************
  logic [2:0] bestLvl;
  logic [5:0] bestIdx;
  logic bestRouted;
  logic [2:0] bestCh;
  logic [2:0] maskNow;

  always_comb begin
    logic [3:0] rt;
    logic [2:0] lv;
    rt = 4'h0;
    lv = LEVEL_NONE;
    bestLvl = LEVEL_NONE;
    bestIdx = 6'h00;
    bestRouted = 1'b0;
    bestCh = 3'h0;
    // Scanning downward with >= leaves the smallest vector on ties.
    for (int i = NSRC - 1; i >= WATCHDOG_IDX; i--) begin
      rt = route(s_q.startCode, i);
      lv = effLevel(s_q.pend[i], s_q.level[i], rt[3], i);
      if (lv != LEVEL_NONE && lv >= bestLvl) begin
        bestLvl = lv;
        bestIdx = 6'(i);
        bestRouted = rt[3];
        bestCh = rt[2:0];
      end
    end
  end

  assign maskNow = s_q.sr[SR_MASK_HI:SR_MASK_LO];

  // **************************************************************
  // Next state
  // **************************************************************
  always_comb begin
    logic hwTake;
    logic [2:0] newMask;
    logic [7:0] vec;
    logic busRd;
    logic busWr;
    int w;
    hwTake = 1'b0;
    newMask = LEVEL_NONE;
    vec = 8'h00;
    busRd = 1'b0;
    busWr = 1'b0;
    w = 0;
    s_d = s_q;
    s_d.pushValid = 1'b0;
    s_d.jumpValid = 1'b0;
    s_d.accepted = 1'b0;
    s_d.xferGo = 1'b0;

    // Events set pending flags; a set in the clearing cycle survives.
    for (int i = WATCHDOG_IDX; i < NSRC; i++) begin
      if (i != RESERVED_IDX && irqEvent[i]) begin
        s_d.pend[i] = 1'b1;
      end
    end

    // Instructions that touch the mask act at once.
    if (opValid) begin
      case (opKind)
        OP_MASK_SET: begin
          newMask = (opArg == LEVEL_NONE) ? LEVEL_MIN : opArg;
          s_d.sr[SR_MASK_HI:SR_MASK_LO] = newMask;
        end
        OP_MASK_ALL: begin
          s_d.sr[SR_MASK_HI:SR_MASK_LO] = LEVEL_TOP;
        end
        OP_RETURN: begin
          s_d.sr = retSr;
          if (s_q.nest != 8'h00) begin
            s_d.nest = s_q.nest - 8'h01;
          end
        end
        default: begin
        end
      endcase
    end

    case (s_q.st)
      ST_IDLE: begin
        if (instrBoundary && !opValid) begin
          if (trapReq || illegalReq) begin
            // Traps skip the mask update but still fetch their handler from the vector area.
            vec = illegalReq ? vectorOf(6'(ILLEGAL_TRAP_IDX))
                             : vectorOf({3'h0, trapNum});
            s_d.vector = vec;
            s_d.accepted = 1'b1;
            s_d.nest = s_q.nest + 8'h01;
            s_d.pushValid = 1'b1;
            s_d.pushAddr = stackPointer;
            s_d.pushPc = pcIn;
            s_d.pushSr = s_q.sr;
            s_d.st = ST_PUSH;
          end else if (bestLvl != LEVEL_NONE && bestLvl >= maskNow) begin
            hwTake = 1'b1;
          end
        end
        if (hwTake) begin
          s_d.pend[bestIdx] = irqEvent[bestIdx];
          if (bestRouted) begin
            s_d.xferGo = 1'b1;
            s_d.xferCh = bestCh;
          end else begin
            s_d.vector = vectorOf(bestIdx);
            s_d.accepted = 1'b1;
            newMask = (bestLvl == LEVEL_TOP) ? LEVEL_TOP
                                             : bestLvl + 3'h1;
            s_d.sr[SR_MASK_HI:SR_MASK_LO] = newMask;
            s_d.nest = s_q.nest + 8'h01;
            s_d.pushValid = 1'b1;
            s_d.pushAddr = stackPointer;
            s_d.pushPc = pcIn;
            s_d.pushSr = s_q.sr;
            s_d.st = ST_PUSH;
          end
        end
      end
      ST_PUSH: begin
        s_d.fetchReq = 1'b1;
        s_d.fetchAddr = VECTOR_BASE + {16'h0000, s_q.vector};
        s_d.st = ST_FETCH;
      end
      ST_FETCH: begin
        if (fetchAck) begin
          s_d.fetchReq = 1'b0;
          s_d.jumpValid = 1'b1;
          s_d.jumpTarget = fetchData;
          s_d.st = ST_JUMP;
        end
      end
      ST_JUMP: begin
        s_d.st = ST_HOLD;
      end
      ST_HOLD: begin
        // No request is accepted until the handler's first instruction ran.
        if (instrDone) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // A finished transfer frees its channel and flags its done source.
    if (xferEnd) begin
      s_d.startCode[xferEndCh] = 8'h00;
      s_d.pend[XFER_DONE_BASE + int'(xferEndCh)] = 1'b1;
    end

    // Register slave: one wait cycle, then the access completes.
    busRd = read && !s_q.wait_;
    busWr = write && !s_q.wait_;
    s_d.wait_ = !((read || write) && s_q.wait_);
    if (read && s_q.wait_) begin
      s_d.rdata = 32'h00000000;
      if (address == REG_STATUS) begin
        s_d.rdata = {5'h00, s_q.st, s_q.nest, s_q.sr};
      end else if (address == REG_PEND_LO) begin
        s_d.rdata = 32'(s_q.pend);
      end else if (address == REG_PEND_HI) begin
        s_d.rdata = 32'(s_q.pend >> 32);
      end else if (address >= REG_LEVEL_BASE && address <= REG_LEVEL_END
                   && address[1:0] == 2'b00) begin
        w = int'(address - REG_LEVEL_BASE) >> 2;
        for (int k = 0; k < LEVELS_PER_WORD; k++) begin
          if (w * LEVELS_PER_WORD + k < NSRC) begin
            s_d.rdata[k*LEVEL_FIELD +: 3] =
              s_q.level[w * LEVELS_PER_WORD + k];
          end
        end
      end else if (address >= REG_START_BASE && address <= REG_START_END
                   && address[1:0] == 2'b00) begin
        w = int'(address - REG_START_BASE) >> 2;
        s_d.rdata = {24'h000000, s_q.startCode[w]};
      end
    end
    if (busWr) begin
      if (address >= REG_LEVEL_BASE && address <= REG_LEVEL_END
          && address[1:0] == 2'b00) begin
        w = int'(address - REG_LEVEL_BASE) >> 2;
        for (int k = 0; k < LEVELS_PER_WORD; k++) begin
          if (w * LEVELS_PER_WORD + k >= NUM_FIXED
              && w * LEVELS_PER_WORD + k < NSRC) begin
            s_d.level[w * LEVELS_PER_WORD + k] =
              writedata[k*LEVEL_FIELD +: 3];
          end
        end
      end else if (address >= REG_START_BASE && address <= REG_START_END
                   && address[1:0] == 2'b00) begin
        w = int'(address - REG_START_BASE) >> 2;
        s_d.startCode[w] = writedata[7:0];
      end
    end
    if (busRd) begin
      s_d.rdata = s_q.rdata;
    end
  end

  // **************************************************************
  // Registers
  // **************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.sr <= SR_RESET;
      s_q.wait_ <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata = s_q.rdata;
  assign waitrequest = s_q.wait_;
  assign pushValid = s_q.pushValid;
  assign pushAddr = s_q.pushAddr;
  assign pushPc = s_q.pushPc;
  assign pushSr = s_q.pushSr;
  assign fetchReq = s_q.fetchReq;
  assign fetchAddr = s_q.fetchAddr;
  assign jumpValid = s_q.jumpValid;
  assign jumpTarget = s_q.jumpTarget;
  assign statusReg = s_q.sr;
  assign nestDepth = s_q.nest;
  assign accepted = s_q.accepted;
  assign acceptedVector = s_q.vector;
  assign xferGo = s_q.xferGo;
  assign xferCh = s_q.xferCh;

endmodule

// ==== verification/irq_ctrl_monitor.sv ====
// Checker for the acceptance sequencer of the interrupt controller.
`timescale 1ns/100ps
module irq_ctrl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sequencer side
  input wire logic opValid,
  input wire irq_ctrl_pkg::op_kind_t opKind,
  input wire logic [2:0] opArg,
  input wire logic [15:0] retSr,
  input wire logic trapReq,
  input wire logic illegalReq,
  input wire logic [31:0] stackPointer,
  input wire logic fetchAck,
  input wire logic [23:0] fetchData,
  // Design outputs
  input wire logic pushValid,
  input wire logic [31:0] pushAddr,
  input wire logic fetchReq,
  input wire logic [23:0] fetchAddr,
  input wire logic jumpValid,
  input wire logic [23:0] jumpTarget,
  input wire logic [15:0] statusReg,
  input wire logic [7:0] nestDepth,
  input wire logic accepted,
  input wire logic xferGo
);
  import irq_ctrl_pkg::*;
  logic [2:0] mask;
  assign mask = statusReg[14:12];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  push_ctx_a: assert property (
    accepted |-> pushValid && pushAddr == $past(stackPointer))
    else $error("context push wrong");
  nest_up_a: assert property (
    accepted |-> nestDepth == $past(nestDepth) + 8'h01)
    else $error("nesting depth not raised");
  mask_raise_a: assert property (
    accepted && !$past(trapReq || illegalReq)
      |-> mask > $past(mask) || mask == 3'h7)
    else $error("mask not raised on acceptance");
  trap_mask_a: assert property (
    accepted && $past(trapReq || illegalReq) |-> mask == $past(mask))
    else $error("trap changed the mask");
  fetch_addr_a: assert property (
    pushValid |=> fetchReq && fetchAddr[23:8] == 16'hFFFF)
    else $error("handler fetch wrong");
  jump_target_a: assert property (
    fetchReq && fetchAck |=> jumpValid && jumpTarget == $past(fetchData))
    else $error("jump target wrong");
  mask_set_a: assert property (
    opValid && opKind == OP_MASK_SET
      |=> mask == ($past(opArg) == 3'h0 ? 3'h1 : $past(opArg)))
    else $error("mask set wrong");
  mask_all_a: assert property (
    opValid && opKind == OP_MASK_ALL |=> mask == 3'h7)
    else $error("mask all wrong");
  return_ctx_a: assert property (
    opValid && opKind == OP_RETURN |=> statusReg == $past(retSr)
      && nestDepth == ($past(nestDepth) == 8'h00 ? 8'h00
      : $past(nestDepth) - 8'h01))
    else $error("return wrong");
  cover property (accepted && mask == 3'h7);
  cover property (xferGo);
  cover property (opValid && opKind == OP_RETURN && nestDepth == 8'h02);
endmodule

// ==== verification/cpu_seq_model.sv ====
// Behavioural CPU core side: answers handler fetches, ends handler entry.
`timescale 1ns/100ps
module cpu_seq_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pacing from the bench
  input wire logic slow,
  // Handler fetch
  input wire logic fetchReq,
  input wire logic [23:0] fetchAddr,
  output logic fetchAck,
  output logic [23:0] fetchData,
  // Handler entry
  input wire logic jumpValid,
  output logic instrDone
);
  int waitCnt;
  int doneCnt;
  // Between answers the word toggles, so a stale capture cannot pass.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetchAck <= 1'b0;
      fetchData <= 24'h000000;
      instrDone <= 1'b0;
      waitCnt <= 0;
      doneCnt <= 0;
    end else begin
      fetchAck <= 1'b0;
      instrDone <= 1'b0;
      fetchData <= ~fetchData;
      if (fetchReq && !fetchAck) begin
        waitCnt <= waitCnt + 1;
        if (waitCnt >= (slow ? 4 : 0)) begin
          fetchAck <= 1'b1;
          fetchData <= {16'hC000, fetchAddr[7:0]};
          waitCnt <= 0;
        end
      end
      if (jumpValid) begin
        doneCnt <= 3;
      end else if (doneCnt != 0) begin
        doneCnt <= doneCnt - 1;
        instrDone <= (doneCnt == 1);
      end
    end
  end
endmodule

// ==== verification/tb_priority_interrupt_controller.sv ====
// Self-checking bench for the priority interrupt controller.
`timescale 1ns/100ps
module tb_priority_interrupt_controller;
  import irq_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [NUM_SOURCES-1:0] irqEvent = '0;
  logic opValid = 1'b0;
  op_kind_t opKind = OP_NONE;
  logic [2:0] opArg = 3'h0;
  logic [15:0] retSr = 16'h0;
  logic trapReq = 1'b0;
  logic illegalReq = 1'b0;
  logic [2:0] trapNum = 3'h0;
  logic xferEnd = 1'b0;
  logic waitrequest, fetchAck, instrDone, jumpValid, pushValid;
  logic fetchReq, accepted, xferGo;
  logic [31:0] readdata, pushAddr;
  logic [23:0] fetchData, fetchAddr, jumpTarget, pushPc;
  logic [15:0] pushSr, statusReg;
  logic [7:0] nestDepth, acceptedVector;
  logic [2:0] xferCh;
  int fails = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  priority_interrupt_controller dut (.clk, .rstn, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .irqEvent,
    .instrBoundary(1'b1), .instrDone, .opValid, .opKind, .opArg, .retSr,
    .trapReq, .trapNum, .illegalReq, .pcIn(24'h123456),
    .stackPointer(32'h00008000), .fetchAck, .fetchData, .xferEnd,
    .xferEndCh(3'h0), .pushValid, .pushAddr, .pushPc, .pushSr, .fetchReq,
    .fetchAddr, .jumpValid, .jumpTarget, .statusReg, .nestDepth,
    .accepted, .acceptedVector, .xferGo, .xferCh);
  cpu_seq_model model (.clk, .rstn, .slow, .fetchReq, .fetchAddr,
    .fetchAck, .fetchData, .jumpValid, .instrDone);
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The request holds until the edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      chk("waitrequest", 32'h0, {31'h0, waitrequest});
      test_done();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic op(input op_kind_t k, input logic [2:0] a,
      input logic [15:0] sr);
    @(posedge clk);
    opValid <= 1'b1;
    opKind <= k;
    opArg <= a;
    retSr <= sr;
    @(posedge clk);
    opValid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic pulse(input logic [NUM_SOURCES-1:0] ev, input logic t,
      input logic il, input logic [2:0] n);
    @(posedge clk);
    irqEvent <= ev;
    trapReq <= t;
    illegalReq <= il;
    trapNum <= n;
    @(posedge clk);
    irqEvent <= '0;
    trapReq <= 1'b0;
    illegalReq <= 1'b0;
    @(negedge clk);
  endtask
  task automatic quiet(input string what);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      chk(what, 32'h0, {31'h0, accepted});
    end
  endtask
  task automatic take(input logic [7:0] v, input logic [2:0] m,
      input logic [7:0] nest, input logic [15:0] sr, input logic trap);
    int i;
    for (i = 0; i < 40 && accepted !== 1'b1; i++) @(negedge clk);
    chk("accepted", 32'h1, {31'h0, accepted});
    if (accepted !== 1'b1) test_done();
    if (!trap) chk("vector", v, acceptedVector);
    chk("mask", m, statusReg[14:12]);
    chk("nest", nest, nestDepth);
    chk("pushed sr", sr, pushSr);
    chk("pushed pc", 24'h123456, pushPc);
    for (i = 0; i < 40 && jumpValid !== 1'b1; i++) @(negedge clk);
    chk("jump", {16'hC000, v}, jumpTarget);
    repeat (5) @(negedge clk);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    chk("status reg", 32'h7000, statusReg);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk("status word", 32'h7000, q);
    bus(1'b0, 8'hF0, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_masks();
    for (int a = 0; a < 8; a++) begin
      op(OP_MASK_SET, a[2:0], 16'h0);
      chk("mask set", (a == 0) ? 1 : a, statusReg[14:12]);
      op(OP_MASK_ALL, 3'h2, 16'h0);
      chk("mask all", 32'h7, statusReg[14:12]);
    end
  endtask
  task automatic t_levels();
    logic [31:0] q;
    bus(1'b1, 8'h18, 32'h33000000, q);
    bus(1'b1, 8'h1C, 32'h00000007, q);
    bus(1'b0, 8'h18, 32'h0, q);
    chk("level word", 32'h33000000, q);
    op(OP_MASK_SET, 3'h4, 16'h0);
    pulse(60'h3C00000, 1'b0, 1'b0, 3'h0);
    quiet("below mask");
    bus(1'b0, REG_PEND_LO, 32'h0, q);
    chk("pending", 32'h03C00000, q);
    op(OP_MASK_SET, 3'h3, 16'h0);
    take(8'h58, 3'h4, 8'h01, 16'h3000, 1'b0);
    bus(1'b0, REG_PEND_LO, 32'h0, q);
    chk("pending", 32'h03800000, q);
    pulse(60'h200, 1'b0, 1'b0, 3'h0);
    take(8'h24, 3'h7, 8'h02, 16'h4000, 1'b0);
    op(OP_RETURN, 3'h0, 16'h4000);
    chk("nest", 32'h1, nestDepth);
    quiet("served level");
    op(OP_RETURN, 3'h0, 16'h3000);
    take(8'h5C, 3'h4, 8'h01, 16'h3000, 1'b0);
    op(OP_RETURN, 3'h0, 16'h1000);
    quiet("level 0 or 7");
  endtask
  task automatic t_trap();
    op(OP_MASK_ALL, 3'h0, 16'h0);
    pulse('0, 1'b1, 1'b0, 3'h5);
    take(8'h14, 3'h7, 8'h01, 16'h7000, 1'b1);
    op(OP_RETURN, 3'h0, 16'h7000);
    pulse('0, 1'b0, 1'b1, 3'h0);
    take(8'h08, 3'h7, 8'h01, 16'h7000, 1'b1);
    op(OP_RETURN, 3'h0, 16'h7000);
  endtask
  task automatic t_xfer();
    logic [31:0] q;
    int i;
    bus(1'b1, REG_START_BASE, 32'h16, q);
    op(OP_MASK_SET, 3'h6, 16'h0);
    pulse(60'h400000, 1'b0, 1'b0, 3'h0);
    for (i = 0; i < 40 && xferGo !== 1'b1; i++) @(negedge clk);
    chk("transfer go", 32'h1, {31'h0, xferGo});
    chk("channel", 32'h0, xferCh);
    quiet("routed");
    @(posedge clk);
    xferEnd <= 1'b1;
    @(posedge clk);
    xferEnd <= 1'b0;
    bus(1'b0, REG_PEND_HI, 32'h0, q);
    chk("done pending", 32'h00100000, q);
    bus(1'b0, REG_START_BASE, 32'h0, q);
    chk("start cleared", 32'h0, q);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_masks();
    t_levels();
    slow <= 1'b1;
    t_trap();
    t_xfer();
    test_done();
  end
endmodule
bind priority_interrupt_controller irq_ctrl_monitor mon (.clk, .rstn,
  .opValid, .opKind, .opArg, .retSr, .trapReq, .illegalReq, .stackPointer,
  .fetchAck, .fetchData, .pushValid, .pushAddr, .fetchReq, .fetchAddr,
  .jumpValid, .jumpTarget, .statusReg, .nestDepth, .accepted, .xferGo);
